// ==== adcsyn_ctrl.sv ====
// Sequencer, error flags, register monitor and error pin of the converter, with APB registers
`include "adcsyn_params.svh"
module adcsyn_ctrl (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [9:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Converter core
  output logic                            conv_start,
  output logic      [1:0]                 conv_chan,
  input  wire logic                       conv_done,
  input  wire adcsyn_pkg::adcsyn_result_s conv_res,
  // Serial port checksum checker
  input  wire logic                       crc_mismatch,
  // Pins
  input  wire logic                       sync_gate_n,
  input  wire logic                       fault_in,
  output logic                            fault_out,
  output logic                            fault_oe_n,
  // Conversion output
  output logic                            out_valid,
  output adcsyn_pkg::adcsyn_out_s         out_data,
  output logic                            drdy_n
);
  import adcsyn_pkg::*;

  logic [15:0]     if_cfg;
  logic [15:0]     gp_cfg;
  logic [15:0]     ch_cfg [4];
  logic [79:0]     mon_vec;
  logic [79:0]     snap;
  logic [23:0]     regchk;
  logic [23:0]     data_code;
  logic [1:0]      data_chan;
  logic            conv_err;
  logic            crc_err;
  logic            reg_err;
  logic            gate_s1;
  logic            gate_s2;
  logic            pin_s1;
  logic            pin_s2;
  logic            gate_req;
  logic [31:0]     rd_val;
  logic [3:0]      ch_en;
  adcsyn_state_e   state;
  adcsyn_pinmode_e pinmode;
  adcsyn_status_s  status;
  adcsyn_status_s  out_status;

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == `ADCSYN_IDX_STATUS) || (i == `ADCSYN_IDX_INTF) || (i == `ADCSYN_IDX_REGCHK) ||
                (i == `ADCSYN_IDX_DATA) || (i == `ADCSYN_IDX_PINCFG) ||
                (i >= `ADCSYN_IDX_CH0 && i <= `ADCSYN_IDX_CH3);
  endfunction

  function automatic logic is_writable(input logic [7:0] i);
    is_writable = (i == `ADCSYN_IDX_INTF) || (i == `ADCSYN_IDX_PINCFG) ||
                  (i >= `ADCSYN_IDX_CH0 && i <= `ADCSYN_IDX_CH3);
  endfunction

  // Next enabled channel after cur, wrapping round
  function automatic logic [1:0] next_chan(input logic [1:0] cur, input logic [3:0] en);
    logic [1:0] c;
    c = cur;
    next_chan = cur;
    for (int k = 0; k < 4; k++)
    begin
      c = c + 2'd1;
      if (en[c] && next_chan == cur)
        next_chan = c;
    end
    if (!en[next_chan])
      next_chan = cur;
  endfunction

  wire [7:0] idx    = paddr[9:2];
  wire       acc    = psel & penable & pready;
  wire       wr_acc = acc & pwrite & is_writable(idx);
  wire       rd_acc = acc & ~pwrite;
  wire       alt_en = if_cfg[`ADCSYN_IF_ALT];
  wire       gate_low = ~gate_s2;
  wire       done_ok = conv_done & (state == ADCSYN_CONV);
  wire       oor     = conv_res.over | conv_res.under;
  wire       any_err = conv_err | crc_err | reg_err;
  wire       chk_off_wr = wr_acc & (idx == `ADCSYN_IDX_INTF) & ~pwdata[`ADCSYN_IF_RCHK];
  wire       pin_bit = (pinmode == ADCSYN_PIN_IN) ? pin_s2 : gp_cfg[`ADCSYN_GP_PINVAL];

  assign pinmode = adcsyn_pinmode_e'(gp_cfg[`ADCSYN_GP_MODE_HI:`ADCSYN_GP_MODE_LO]);

  // Two-stage synchronisers for the pins
  always_ff @(posedge clk)
  begin
    gate_s1 <= sync_gate_n;
    gate_s2 <= gate_s1;
    pin_s1  <= fault_in;
    pin_s2  <= pin_s1;
  end

  // APB: one wait state, answer registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr <= ~is_mapped(idx) | (pwrite & ~is_writable(idx));
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (idx)
      `ADCSYN_IDX_STATUS:  rd_val = {24'h00_0000, status};
      `ADCSYN_IDX_INTF:    rd_val = {16'h0000, if_cfg};
      `ADCSYN_IDX_REGCHK:  rd_val = {8'h00, regchk};
      `ADCSYN_IDX_DATA:    rd_val = {8'h00, data_code};
      `ADCSYN_IDX_PINCFG:  rd_val = {16'h0000, gp_cfg[15:9], pin_bit, gp_cfg[7:0]};
      default:
      begin
        if (idx >= `ADCSYN_IDX_CH0 && idx <= `ADCSYN_IDX_CH3)
          rd_val = {16'h0000, ch_cfg[idx[1:0]]};
      end
    endcase
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      if_cfg <= `ADCSYN_RST_INTF;
      gp_cfg <= `ADCSYN_RST_PINCFG;
      ch_cfg[0] <= `ADCSYN_RST_CH0;
      for (int k = 1; k < 4; k++)
        ch_cfg[k] <= `ADCSYN_RST_CHN;
    end
    else if (wr_acc)
    begin
      if (idx == `ADCSYN_IDX_INTF)
        if_cfg <= pwdata[15:0];
      if (idx == `ADCSYN_IDX_PINCFG)
        gp_cfg <= pwdata[15:0];
      for (int k = 0; k < 4; k++)
        if (idx == `ADCSYN_IDX_CH0 + 8'(k))
          ch_cfg[k] <= pwdata[15:0];
    end
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_chen
    assign ch_en[g] = ch_cfg[g][`ADCSYN_CH_EN];
  end

  // monitored set excludes data, status, interface config
  assign mon_vec = {gp_cfg, ch_cfg[0], ch_cfg[1], ch_cfg[2], ch_cfg[3]};

  // Sequencer; a gate pulse during a conversion is remembered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state      <= ADCSYN_IDLE;
      conv_start <= 1'b0;
      conv_chan  <= 2'd0;
      gate_req   <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      case (state)
        ADCSYN_IDLE:
        begin
          if (|ch_en)
          begin
            conv_chan  <= next_chan(2'd3, ch_en);
            conv_start <= 1'b1;
            state      <= ADCSYN_CONV;
          end
        end
        ADCSYN_CONV:
        begin
          if (alt_en && gate_low)
            gate_req <= 1'b1;
          if (conv_done)
          begin
            gate_req  <= 1'b0;
            conv_chan <= next_chan(conv_chan, ch_en);
            if (!(|ch_en))
              state <= ADCSYN_IDLE;
            else if (alt_en && (gate_low || gate_req))
              state <= ADCSYN_HOLD;
            else
              conv_start <= 1'b1;
          end
        end
        ADCSYN_HOLD:
        begin
          if (!(|ch_en))
            state <= ADCSYN_IDLE;
          else if (!alt_en || !gate_low)
          begin
            conv_start <= 1'b1;
            state      <= ADCSYN_CONV;
          end
        end
        default: state <= ADCSYN_IDLE;
      endcase
    end
  end

  always_comb
  begin
    status          = '0;
    status.rdy_n    = drdy_n;
    status.conv_err = conv_err;
    status.crc_err  = crc_err;
    status.reg_err  = reg_err;
    status.chan     = data_chan;
    out_status          = status;
    out_status.rdy_n    = 1'b0;
    out_status.conv_err = conv_err | oor;
    out_status.chan     = conv_chan;
  end

  // Result capture and output word
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      data_code <= 24'h00_0000;
      data_chan <= 2'd0;
      drdy_n    <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= 1'b0;
      if (done_ok)
      begin
        if (conv_res.over)
          data_code <= 24'hff_ffff;
        else if (conv_res.under)
          data_code <= 24'h00_0000;
        else
          data_code <= conv_res.code;
        data_chan <= conv_chan;
        drdy_n    <= 1'b0;
        out_valid <= 1'b1;
        out_data.code <= conv_res.over ? 24'hff_ffff : (conv_res.under ? 24'h00_0000 : conv_res.code);
        out_data.with_status <= if_cfg[`ADCSYN_IF_DSTAT];
        out_data.status      <= if_cfg[`ADCSYN_IF_DSTAT] ? out_status : '0;
      end
      else if (rd_acc && idx == `ADCSYN_IDX_DATA)
        drdy_n <= 1'b1;
    end
  end

  // Error flags
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_err <= 1'b0;
      crc_err  <= 1'b0;
      reg_err  <= 1'b0;
      snap     <= '0;
      regchk   <= 24'h00_0000;
    end
    else
    begin
      if ((done_ok && oor) || (pinmode == ADCSYN_PIN_IN && !pin_s2))
        conv_err <= 1'b1;
      else if (!oor)
        conv_err <= 1'b0;
      // set beats the status-read clear; a flag raised after the word was latched survives
      if (crc_mismatch)
        crc_err <= 1'b1;
      else if (rd_acc && idx == `ADCSYN_IDX_STATUS && prdata[`ADCSYN_ST_CRC])
        crc_err <= 1'b0;
      // disable write clears, beating a late change
      if (chk_off_wr)
        reg_err <= 1'b0;
      else if (if_cfg[`ADCSYN_IF_RCHK] && mon_vec != snap)
        reg_err <= 1'b1;
      if (!if_cfg[`ADCSYN_IF_RCHK])
        snap <= mon_vec;
      regchk <= if_cfg[`ADCSYN_IF_RCHK] ?
                {8'h00, snap[79:64] ^ snap[63:48] ^ snap[47:32] ^ snap[31:16] ^ snap[15:0]} : 24'h00_0000;
    end
  end

  // Error pin; open-drain mode leans on the board pull-up
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fault_out  <= 1'b0;
      fault_oe_n <= 1'b1;
    end
    else
    begin
      case (pinmode)
        ADCSYN_PIN_OD:
        begin
          fault_out  <= 1'b0;
          fault_oe_n <= ~any_err;
        end
        ADCSYN_PIN_GPO:
        begin
          fault_out  <= gp_cfg[`ADCSYN_GP_PINVAL];
          fault_oe_n <= 1'b0;
        end
        default:
        begin
          fault_out  <= 1'b0;
          fault_oe_n <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_alt_hold_entry: assert property (alt_en && done_ok && gate_low && (|ch_en) |=> state == ADCSYN_HOLD)
    else $error("gate low at completion did not hold");
  a_hold_release: assert property (state == ADCSYN_HOLD && alt_en && gate_low |=> !conv_start)
    else $error("conversion started while gate low");
  a_ready_low: assert property (done_ok |=> !drdy_n && out_valid)
    else $error("completion did not raise ready");
  a_range_flag: assert property (done_ok && oor |=> conv_err)
    else $error("out of range did not set error");
  a_clamp_code: assert property (done_ok && conv_res.over |=> data_code == 24'hff_ffff)
    else $error("overvoltage code not all ones");
  a_clamp_zero: assert property (done_ok && conv_res.under && !conv_res.over |=> data_code == 24'h00_0000)
    else $error("undervoltage code not all zeros");
  a_err_persist: assert property (conv_err && oor |=> conv_err)
    else $error("conversion error cleared early");
  a_crc_set: assert property (crc_mismatch |=> crc_err)
    else $error("checksum mismatch not flagged");
  a_crc_hold: assert property (crc_err && !crc_mismatch && !(rd_acc && idx == `ADCSYN_IDX_STATUS) |=> crc_err)
    else $error("checksum flag lost without status read");
  a_reg_change: assert property (if_cfg[`ADCSYN_IF_RCHK] && mon_vec != snap && !chk_off_wr |=> reg_err)
    else $error("register change not flagged");
  a_reg_clear: assert property (reg_err && !chk_off_wr |=> reg_err)
    else $error("register error cleared wrongly");
  a_mon_scope: assert property (wr_acc && idx == `ADCSYN_IDX_INTF |=> $stable(mon_vec))
    else $error("interface config entered monitor");
  a_od_drive: assert property (pinmode == ADCSYN_PIN_OD && any_err |=> !fault_oe_n && !fault_out)
    else $error("error pin not pulled low");
  a_pin_input: assert property (pinmode == ADCSYN_PIN_IN && !pin_s2 |=> conv_err)
    else $error("external error not merged");
  a_pin_value: assert property (pinmode == ADCSYN_PIN_IN |-> pin_bit == pin_s2)
    else $error("pin value not reflected");
  a_pin_off: assert property (pinmode == ADCSYN_PIN_OFF |=> fault_oe_n)
    else $error("disabled pin driven");
  a_pin_gpo: assert property (pinmode == ADCSYN_PIN_GPO |=> !fault_oe_n && fault_out == $past(gp_cfg[8]))
    else $error("general output level wrong");
  a_stat_append: assert property (done_ok && if_cfg[`ADCSYN_IF_DSTAT] |=> out_data.with_status)
    else $error("status not appended");
  a_stat_chan: assert property (done_ok && if_cfg[`ADCSYN_IF_DSTAT] |=> out_data.status.chan == $past(conv_chan))
    else $error("appended channel wrong");
  a_od_release: assert property (pinmode == ADCSYN_PIN_OD && !any_err |=> fault_oe_n)
    else $error("error pin not released");

  c_hold: cover property (state == ADCSYN_CONV ##1 state == ADCSYN_HOLD ##[1:100] state == ADCSYN_CONV);
  c_crc: cover property (crc_err ##1 !crc_err);
  c_reg: cover property (reg_err ##[1:20] !reg_err);
  c_append: cover property (out_valid && out_data.with_status);
endmodule // adcsyn_ctrl

// ==== adcsyn_params.svh ====
// Register indices, field positions and reset values of the converter control block
`ifndef ADCSYN_PARAMS_SVH
`define ADCSYN_PARAMS_SVH
`define ADCSYN_IDX_STATUS   8'h00
`define ADCSYN_IDX_INTF     8'h02
`define ADCSYN_IDX_REGCHK   8'h03
`define ADCSYN_IDX_DATA     8'h04
`define ADCSYN_IDX_PINCFG   8'h06
`define ADCSYN_IDX_CH0      8'h10
`define ADCSYN_IDX_CH3      8'h13
`define ADCSYN_IF_ALT       12
`define ADCSYN_IF_DSTAT     6
`define ADCSYN_IF_RCHK      5
`define ADCSYN_GP_MODE_HI   10
`define ADCSYN_GP_MODE_LO   9
`define ADCSYN_GP_PINVAL    8
`define ADCSYN_CH_EN        15
`define ADCSYN_ST_CRC       5
`define ADCSYN_RST_INTF     16'h0000
`define ADCSYN_RST_PINCFG   16'h0800
`define ADCSYN_RST_CH0      16'h8001
`define ADCSYN_RST_CHN      16'h0001
`endif

// ==== adcsyn_pkg.sv ====
// Types shared by the converter control block
package adcsyn_pkg;
  typedef enum logic [1:0] {
    ADCSYN_PIN_OFF = 2'b00,
    ADCSYN_PIN_IN  = 2'b01,
    ADCSYN_PIN_OD  = 2'b10,
    ADCSYN_PIN_GPO = 2'b11
  } adcsyn_pinmode_e;
  typedef enum logic [2:0] {
    ADCSYN_IDLE = 3'b001,
    ADCSYN_CONV = 3'b010,
    ADCSYN_HOLD = 3'b100
  } adcsyn_state_e;
  typedef struct packed {
    logic       rdy_n;
    logic       conv_err;
    logic       crc_err;
    logic       reg_err;
    logic [1:0] rsvd;
    logic [1:0] chan;
  } adcsyn_status_s;
  typedef struct packed {
    logic [23:0] code;
    logic        over;
    logic        under;
  } adcsyn_result_s;
  typedef struct packed {
    logic [23:0]    code;
    adcsyn_status_s status;
    logic           with_status;
  } adcsyn_out_s;
endpackage

// ==== adcsyn_core_model.sv ====
// Behavioural converter core that answers the control block's start pulses
module adcsyn_core_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Start request
  input  wire logic                  conv_start,
  input  wire logic [1:0]            conv_chan,
  // Conversion length and input condition
  input  wire logic [7:0]            lat,
  input  wire logic                  over,
  input  wire logic                  under,
  // Result
  output logic                       conv_done,
  output adcsyn_pkg::adcsyn_result_s conv_res
);
  timeunit 1ns;
  timeprecision 1ns;
  import adcsyn_pkg::*;
  logic [7:0]  cnt;
  logic        busy;
  logic [1:0]  ch;
  logic [23:0] val;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      cnt <= 8'h00;
      ch <= 2'b00;
    end
    else
    begin
      conv_done <= busy && cnt == 8'h00 && !conv_start;
      if (conv_start)
      begin
        busy <= 1'b1;
        cnt <= lat;
        ch <= conv_chan;
      end
      else if (busy)
      begin
        busy <= cnt != 8'h00;
        cnt <= cnt - 8'h01;
      end
    end
  end

  // Raw code even out of range, so the control block must clamp it itself
  assign val = {16'h5a5a, 6'h00, ch};
  // Stale code shown inverted so a late sample cannot pass
  assign conv_res = '{code: (conv_done ? val : ~val), over: over, under: under};
endmodule // adcsyn_core_model

// ==== adc_sync_and_error_status_tb.sv ====
// Self-checking bench of the converter control block
`include "adcsyn_params.svh"
module adc_sync_and_error_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adcsyn_pkg::*;
  localparam logic [7:0]  RIDX [5] = '{`ADCSYN_IDX_INTF, `ADCSYN_IDX_REGCHK, `ADCSYN_IDX_PINCFG,
                                       `ADCSYN_IDX_CH0, `ADCSYN_IDX_CH3};
  localparam logic [31:0] RVAL [5] = '{32'(`ADCSYN_RST_INTF), 32'h0, 32'(`ADCSYN_RST_PINCFG),
                                       32'(`ADCSYN_RST_CH0), 32'(`ADCSYN_RST_CHN)};
  localparam logic [31:0] PMODE [4] = '{32'h0400, 32'h0700, 32'h0600, 32'h0000};
  localparam logic [1:0]  PEXP [4] = '{2'b10, 2'b01, 2'b00, 2'b10};
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [9:0]     paddr = 10'h000;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           conv_start;
  logic [1:0]     conv_chan;
  logic           conv_done;
  adcsyn_result_s conv_res;
  logic           crc_mismatch = 1'b0;
  logic           sync_gate_n = 1'b1;
  logic           ext_low = 1'b0;
  logic           fault_in;
  logic           fault_out;
  logic           fault_oe_n;
  logic           out_valid;
  adcsyn_out_s    out_data;
  logic           drdy_n;
  logic           over = 1'b0;
  logic           under = 1'b0;
  logic [7:0]     lat = 8'h00;
  logic [31:0]    rd;
  logic           err;
  logic [1:0]     ch;
  int             mismatches = 0;
  int             checks_done = 0;
  int             n;

  always #10 clk = ~clk;
  // Pull-up on the pin; the far device can only pull it low
  assign fault_in = (fault_oe_n ? 1'b1 : fault_out) & ~ext_low;

  adcsyn_ctrl DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done), .conv_res(conv_res),
    .crc_mismatch(crc_mismatch), .sync_gate_n(sync_gate_n), .fault_in(fault_in),
    .fault_out(fault_out), .fault_oe_n(fault_oe_n), .out_valid(out_valid), .out_data(out_data),
    .drdy_n(drdy_n));
  adcsyn_core_model core (.clk(clk), .rst_n(rst_n), .conv_start(conv_start), .conv_chan(conv_chan),
    .lat(lat), .over(over), .under(under), .conv_done(conv_done), .conv_res(conv_res));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("[FAIL] t=%0t no answer on %s", $time, what);
    test_done();
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      hang("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_bit(input logic [7:0] idx, input int b, input logic e, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd[b], e, what);
  endtask

  // Waits for a conversion start or a result, bounded
  task automatic wait_for(input bit start, input int lim, input string what);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((start ? conv_start : out_valid) !== 1'b1 && k < lim);
    if ((start ? conv_start : out_valid) !== 1'b1)
      hang(what);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, RIDX[i], 32'h0);
      chk(rd, RVAL[i], "reset value");
      chk(err, 1'b0, "reset read error");
    end
    apb(1'b1, `ADCSYN_IDX_STATUS, 32'hff);
    chk(err, 1'b1, "status write");
    apb(1'b0, 8'h3f, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    // Gate low must be ignored with the alternate bit clear
    sync_gate_n <= 1'b0;
    apb(1'b1, `ADCSYN_IDX_INTF, 32'h0040);
    apb(1'b1, `ADCSYN_IDX_CH0 + 8'h01, 32'h8001);
    for (int i = 0; i < 6; i++)
    begin
      wait_for(1'b0, 300, "result");
      chk(out_data.code, {16'h5a5a, 6'h00, out_data.status.chan}, "code");
      chk({out_data.with_status, drdy_n, out_data.status.rdy_n}, 3'b100, "ready");
      if (i > 1)
        chk(out_data.status.chan, ch ^ 2'b01, "channel order");
      ch = out_data.status.chan;
    end
    sync_gate_n <= 1'b1;
    lat <= 8'h14;
    wait_for(1'b0, 300, "result");
    apb(1'b0, `ADCSYN_IDX_DATA, 32'h0);
    @(posedge clk);
    chk(drdy_n, 1'b1, "ready after read");
    for (int i = 0; i < 2; i++)
    begin
      over <= (i == 0);
      under <= (i == 1);
      wait_for(1'b0, 300, "result");
      wait_for(1'b0, 300, "result");
      chk(out_data.code, (i == 0) ? 24'hffffff : 24'h0, "rail code");
      chk(out_data.status.conv_err, 1'b1, "range flag");
      apb(1'b0, `ADCSYN_IDX_DATA, 32'h0);
      rd_bit(`ADCSYN_IDX_STATUS, 6, 1'b1, "flag kept");
      over <= 1'b0;
      under <= 1'b0;
      wait_for(1'b0, 300, "result");
      wait_for(1'b0, 300, "result");
      rd_bit(`ADCSYN_IDX_STATUS, 6, 1'b0, "flag gone");
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `ADCSYN_IDX_PINCFG, PMODE[i] | 32'h0800);
      if (i == 0)
      begin
        repeat (4) @(posedge clk);
        chk({fault_oe_n, fault_out & ~fault_oe_n}, 2'b10, "pin released");
        crc_mismatch <= 1'b1;
        @(posedge clk);
        crc_mismatch <= 1'b0;
        repeat (4) @(posedge clk);
        chk({fault_oe_n, fault_out}, 2'b00, "pin low on error");
        rd_bit(`ADCSYN_IDX_STATUS, 5, 1'b1, "checksum flag");
        rd_bit(`ADCSYN_IDX_STATUS, 5, 1'b0, "checksum cleared");
      end
      repeat (4) @(posedge clk);
      chk({fault_oe_n, fault_out & ~fault_oe_n}, PEXP[i], "pin mode");
    end
    apb(1'b1, `ADCSYN_IDX_PINCFG, 32'h0a00);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    rd_bit(`ADCSYN_IDX_STATUS, 6, 1'b1, "pin error");
    rd_bit(`ADCSYN_IDX_PINCFG, 8, 1'b0, "pin level low");
    ext_low <= 1'b0;
    repeat (4) @(posedge clk);
    rd_bit(`ADCSYN_IDX_PINCFG, 8, 1'b1, "pin level high");
    apb(1'b1, `ADCSYN_IDX_PINCFG, 32'h0800);
    // Host arms checking only after its writes
    apb(1'b1, `ADCSYN_IDX_INTF, 32'h0060);
    apb(1'b1, `ADCSYN_IDX_INTF, 32'h0020);
    wait_for(1'b0, 300, "result");
    chk(out_data.with_status, 1'b0, "status not appended");
    rd_bit(`ADCSYN_IDX_STATUS, 4, 1'b0, "unmonitored write");
    apb(1'b1, `ADCSYN_IDX_CH0 + 8'h02, 32'h0002);
    rd_bit(`ADCSYN_IDX_STATUS, 4, 1'b1, "register change");
    apb(1'b1, `ADCSYN_IDX_INTF, 32'h0040);
    rd_bit(`ADCSYN_IDX_STATUS, 4, 1'b0, "check disabled");
    // Two channels enabled before the alternate gate is used
    apb(1'b1, `ADCSYN_IDX_INTF, 32'h1040);
    wait_for(1'b1, 300, "start");
    repeat (3) @(posedge clk);
    sync_gate_n <= 1'b0;
    wait_for(1'b0, 300, "result");
    ch = out_data.status.chan;
    n = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (conv_start === 1'b1)
        n++;
    end
    chk(n, 0, "held start");
    sync_gate_n <= 1'b1;
    wait_for(1'b1, 10, "start");
    chk(conv_chan, ch ^ 2'b01, "next channel");
    test_done();
  end
endmodule // adc_sync_and_error_status_tb
